//--- i2c_slave_regs.vh
`ifndef I2C_SLAVE_REGS_VH
`define I2C_SLAVE_REGS_VH
// register indices on the plain register port
`define ADDR_DATA 2'h0
`define ADDR_OWN 2'h1
`define ADDR_MODE 2'h2
`define ADDR_STAT 2'h3
// port_mode_control fields
`define MODE_MSB 7
`define MODE_LSB 5
`define DEB_MSB 3
`define DEB_LSB 2
`define EN_BIT 1
`define ICF_BIT 0
`define MODE_TWO_WIRE 3'h6
`define MODE_RST 8'hE0
// link_status_control fields
`define DONE_BIT 7
`define MATCH_BIT 6
`define BUSY_BIT 5
`define TX_BIT 4
`define ACKSEND_BIT 3
`define DIR_BIT 2
`define WAKE_BIT 1
`define RXACK_BIT 0
`define STAT_RST 8'h81
`define OWN_RST 8'h00
// debounce lengths in system clocks
`define DEB_NONE 3'h0
`define DEB_TWO 3'h2
`define DEB_FOUR 3'h4
`endif

//--- pin_sync.v
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for one external level
module pin_sync (
  input wire sys_clk,
  input wire arst_n,
  input wire pinIn,
  output reg pinOut
);
  reg stage1;
  // ==========================================
  // first stage is read only by the second
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= 1'b1;
      pinOut <= 1'b1;
    end else begin
      stage1 <= pinIn;
      pinOut <= stage1;
    end
  end
endmodule
`default_nettype wire

//--- line_debounce.v
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_regs.vh"
// accepts a new level only after it has stood for the selected length
module line_debounce (
  input wire sys_clk,
  input wire arst_n,
  input wire [1:0] debSel,
  input wire lineIn,
  output reg lineOut
);
  reg [2:0] stable;
  reg [2:0] need;
  // ==========================================
  // length from the select code, 1x means four
  always @* begin
    case (debSel)
      2'h0: need = `DEB_NONE;
      2'h1: need = `DEB_TWO;
      default: need = `DEB_FOUR;
    endcase
  end
  // ==========================================
  // count cycles the new level has stood
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stable <= 3'h0;
      lineOut <= 1'b1;
    end else if (lineIn == lineOut) begin
      stable <= 3'h0;
    end else if (stable >= need) begin
      lineOut <= lineIn;
      stable <= 3'h0;
    end else begin
      stable <= stable + 3'h1;
    end
  end
endmodule
`default_nettype wire

//--- i2c_slave_ctrl.v
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_regs.vh"
module i2c_slave_ctrl (
  input wire sys_clk,
  input wire arst_n,
  input wire [1:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdata,
  input wire sclIn,
  output reg sclOut,
  output reg sclOe,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOe,
  input wire lowPower,
  output reg wakeReq
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ACK = 3'h2;
  localparam ST_RX = 3'h3;
  localparam ST_TX = 3'h4;
  localparam ST_RXACK = 3'h5;
  localparam ST_HOLD = 3'h6;
  localparam ST_DONE = 3'h7;

  reg [7:0] serialData;
  reg [7:0] ownAddr;
  reg [7:0] modeCtl;
  reg doneFlag, matchFlag, busyFlag, txSel, ackSend, dirFlag;
  reg wakeEn, rxAckFlag;
  reg [2:0] state;
  reg [2:0] afterAck;
  reg [3:0] bitCnt;
  reg [7:0] shiftReg;
  reg holdLow;
  reg sclPrev, sdaPrev;
  reg enPrev;
  wire sclSync, sdaSync, sclClean;
  wire twoWire, active, enRise;
  wire sclRise, sclFall, startSeen, stopSeen;
  wire dataAccess;

  // ==========================================
  // pin conditioning: sync both lines, debounce clock
  pin_sync uSclSync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pinIn(sclIn),
    .pinOut(sclSync)
  );
  pin_sync uSdaSync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pinIn(sdaIn),
    .pinOut(sdaSync)
  );
  line_debounce uSclDeb (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .debSel(modeCtl[`DEB_MSB:`DEB_LSB]),
    .lineIn(sclSync),
    .lineOut(sclClean)
  );

  // ==========================================
  // mode decode; only mode 110 with enable runs this slave
  assign twoWire = (modeCtl[`MODE_MSB:`MODE_LSB] == `MODE_TWO_WIRE);
  assign active = twoWire & modeCtl[`EN_BIT];
  assign enRise = twoWire & modeCtl[`EN_BIT] & ~enPrev;
  assign sclRise = sclClean & ~sclPrev;
  assign sclFall = ~sclClean & sclPrev;
  // data sampled undebounced; edges on it are qualified by a high clock
  assign startSeen = active & sclClean & sclPrev & sdaPrev & ~sdaSync;
  assign stopSeen = active & sclClean & sclPrev & ~sdaPrev & sdaSync;
  assign dataAccess = (regWr | regRd) & (regAddr == `ADDR_DATA);

  // ==========================================
  // line history for edge finding
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      enPrev <= 1'b0;
    end else begin
      sclPrev <= sclClean;
      sdaPrev <= sdaSync;
      enPrev <= twoWire & modeCtl[`EN_BIT];
    end
  end

  // ==========================================
  // control registers written by software
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      modeCtl <= `MODE_RST;
      ownAddr <= `OWN_RST;
      txSel <= 1'b0;
      ackSend <= 1'b0;
      wakeEn <= 1'b0;
    end else if (regWr) begin
      case (regAddr)
        // bit 4 is unimplemented and reads as zero
        `ADDR_MODE: modeCtl <= regWdata & 8'hEF;
        `ADDR_OWN: ownAddr <= regWdata;
        `ADDR_STAT: begin
          txSel <= regWdata[`TX_BIT];
          ackSend <= regWdata[`ACKSEND_BIT];
          wakeEn <= regWdata[`WAKE_BIT];
        end
        default: ;
      endcase
    end
  end
  // txSel and ackSend keep their values across an enable rise

  // ==========================================
  // bus state machine, status flags and data register
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      afterAck <= ST_IDLE;
      bitCnt <= 4'h0;
      shiftReg <= 8'h00;
      serialData <= 8'h00;
      doneFlag <= 1'b1;
      matchFlag <= 1'b0;
      busyFlag <= 1'b0;
      dirFlag <= 1'b0;
      rxAckFlag <= 1'b1;
      holdLow <= 1'b0;
      sdaOut <= 1'b1;
      sdaOe <= 1'b0;
      wakeReq <= 1'b0;
    end else if (!active || enRise) begin
      // disabled or freshly enabled: flags to reset values
      state <= ST_IDLE;
      bitCnt <= 4'h0;
      doneFlag <= 1'b1;
      matchFlag <= 1'b0;
      busyFlag <= 1'b0;
      dirFlag <= 1'b0;
      rxAckFlag <= 1'b1;
      holdLow <= 1'b0;
      sdaOe <= 1'b0;
      wakeReq <= 1'b0;
      if (regWr && regAddr == `ADDR_DATA) begin
        serialData <= regWdata;
      end
    end else begin
      wakeReq <= 1'b0;
      if (regWr && regAddr == `ADDR_DATA) begin
        serialData <= regWdata;
      end
      if (startSeen) begin
        busyFlag <= 1'b1;
        state <= ST_ADDR;
        bitCnt <= 4'h0;
        matchFlag <= 1'b0;
        holdLow <= 1'b0;
        sdaOe <= 1'b0;
      end else if (stopSeen) begin
        busyFlag <= 1'b0;
        state <= ST_IDLE;
        holdLow <= 1'b0;
        sdaOe <= 1'b0;
      end else begin
        case (state)
          ST_ADDR: begin
            if (sclRise) begin
              shiftReg <= {shiftReg[6:0], sdaSync};
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == 4'h8) begin
              bitCnt <= 4'h0;
              if (shiftReg[7:1] == ownAddr[7:1]) begin
                matchFlag <= 1'b1;
                dirFlag <= shiftReg[0];
                sdaOut <= 1'b0;
                sdaOe <= 1'b1;
                wakeReq <= wakeEn & lowPower;
                afterAck <= ST_HOLD;
                state <= ST_ACK;
              end else begin
                matchFlag <= 1'b0;
                state <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            // ack bit stands through the ninth clock
            if (sclFall) begin
              sdaOe <= 1'b0;
              holdLow <= 1'b1;
              state <= afterAck;
            end
          end
          ST_HOLD: begin
            // stretch the clock until software touches the data
            if (dataAccess) begin
              holdLow <= 1'b0;
              if (txSel) begin
                // first bit of the byte being written, or of the data register on a read
                sdaOut <= regWr ? regWdata[7] : serialData[7];
                sdaOe <= regWr ? ~regWdata[7] : ~serialData[7];
                shiftReg <= regWr ? regWdata : serialData;
                bitCnt <= 4'h0;
                doneFlag <= 1'b0;
                state <= ST_TX;
              end else begin
                bitCnt <= 4'h0;
                doneFlag <= 1'b0;
                state <= ST_RX;
              end
            end
          end
          ST_RX: begin
            if (sclRise) begin
              shiftReg <= {shiftReg[6:0], sdaSync};
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == 4'h8) begin
              serialData <= shiftReg;
              doneFlag <= 1'b1;
              sdaOut <= 1'b0;
              sdaOe <= ~ackSend;
              afterAck <= ST_HOLD;
              state <= ST_ACK;
            end
          end
          ST_TX: begin
            if (sclFall) begin
              if (bitCnt == 4'h7) begin
                sdaOe <= 1'b0; // master drives the ack bit
                bitCnt <= 4'h0;
                state <= ST_RXACK;
              end else begin
                sdaOut <= shiftReg[6];
                sdaOe <= ~shiftReg[6];
                shiftReg <= {shiftReg[6:0], 1'b0};
                bitCnt <= bitCnt + 4'h1;
              end
            end
          end
          ST_RXACK: begin
            if (sclRise) begin
              rxAckFlag <= sdaSync;
              doneFlag <= 1'b1;
              // no ack: leave the data line free for STOP
              state <= sdaSync ? ST_DONE : ST_RXACK;
            end else if (sclFall) begin
              holdLow <= 1'b1;
              state <= ST_HOLD;
            end
          end
          ST_DONE: sdaOe <= 1'b0;
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ==========================================
  // clock stretch drive; pin open-drain, enable high when pulling low
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclOut <= 1'b1;
      sclOe <= 1'b0;
    end else begin
      sclOut <= 1'b0;
      sclOe <= active & holdLow & ~dataAccess;
    end
  end

  // ==========================================
  // read data, one cycle after the strobe, zero otherwise
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        `ADDR_DATA: regRdata <= serialData;
        `ADDR_OWN: regRdata <= ownAddr;
        `ADDR_MODE: regRdata <= modeCtl;
        default: regRdata <= {doneFlag, matchFlag, busyFlag, txSel,
          ackSend, dirFlag, wakeEn, rxAckFlag};
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

//--- i2c_slave_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_regs.vh"
module i2c_slave_checker (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic lowPower,
  input wire logic wakeReq
);
  logic [7:0] modeCopy;
  logic [7:0] ownCopy;
  logic [7:0] statCopy;
  wire twoWire = modeCopy[7:5] == `MODE_TWO_WIRE && modeCopy[`EN_BIT];
  wire dataHit = (regWr || regRd) && regAddr == `ADDR_DATA;
  wire modeHit = regWr && regAddr == `ADDR_MODE;
  // =====
  // shadows of software writes; reads are predicted from them
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      modeCopy <= `MODE_RST;
      ownCopy <= `OWN_RST;
      statCopy <= `STAT_RST;
    end else if (regWr) begin
      if (regAddr == `ADDR_MODE) modeCopy <= regWdata;
      if (regAddr == `ADDR_OWN) ownCopy <= regWdata;
      if (regAddr == `ADDR_STAT) statCopy <= regWdata;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  // outputs are registered, so give a disable two cycles to land
  sequence offTwice;
    !twoWire [*2];
  endsequence
  rdata_idle_a: assert property (
    !regRd |=> regRdata == 8'h00) else $error("stray read data");
  own_readback_a: assert property (
    regRd && regAddr == `ADDR_OWN |=> regRdata == ownCopy)
    else $error("own address readback");
  mode_readback_a: assert property (
    regRd && regAddr == `ADDR_MODE |=> regRdata == (modeCopy & 8'hEF))
    else $error("mode readback");
  ctrl_bits_a: assert property (
    regRd && regAddr == `ADDR_STAT
    |=> (regRdata & 8'h18) == (statCopy & 8'h18))
    else $error("control bits lost");
  off_quiet_a: assert property (
    offTwice |-> !sdaOe && !sclOe) else $error("drives while off");
  hold_release_a: assert property (
    sclOe && dataHit |=> !sclOe) else $error("hold not released");
  hold_keep_a: assert property (
    sclOe && twoWire && !dataHit && !modeHit |=> sclOe)
    else $error("hold dropped early");
  wake_pulse_a: assert property (
    wakeReq |-> $past(lowPower) ##1 !wakeReq) else $error("bad wake pulse");
endmodule
`default_nettype wire

//--- i2c_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// bus master model; it only pulls lines low, pull-ups do the rest
module i2c_bus_master (
  output logic sclLow,
  output logic sdaLow,
  input wire logic sclLine,
  input wire logic sdaLine,
  output logic hung
);
  int halfP = 200;
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
    hung = 1'b0;
  end
  // release the clock and wait out stretching, bounded
  task automatic sclUp();
    int n;
    sclLow = 1'b0;
    for (n = 0; n < 4000 && sclLine !== 1'b1; n++) #10;
    if (n == 4000) hung = 1'b1;
  endtask
  // data moves only while the clock is low
  task automatic bitIo(input logic b, output logic r);
    #(halfP / 2) sdaLow = !b;
    #(halfP / 2) sclUp();
    #(halfP / 2) r = sdaLine;
    #(halfP / 2) sclLow = 1'b1;
  endtask
  task automatic start();
    sdaLow = 1'b1;
    #(halfP) sclLow = 1'b1;
  endtask
  task automatic stop();
    #(halfP / 2) sdaLow = 1'b1;
    #(halfP / 2) sclUp();
    #(halfP) sdaLow = 1'b0;
    #(2 * halfP);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ackIn,
                      output logic [7:0] rx, output logic ackOut);
    for (int i = 7; i >= 0; i--) bitIo(tx[i], rx[i]);
    bitIo(ackIn, ackOut);
  endtask
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_regs.vh"
module tb;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] regAddr = 2'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic lowPower = 1'b0;
  logic woke = 1'b0;
  logic [7:0] regRdata, v;
  logic sclOut, sclOe, sdaOut, sdaOe, wakeReq, sclLow, sdaLow, hung, ack;
  int nFail = 0;
  int totalChecks = 0;
  wire sclLine = (sclOe ? sclOut : 1'b1) & !sclLow;
  wire sdaLine = (sdaOe ? sdaOut : 1'b1) & !sdaLow;
  always #25 sys_clk = ~sys_clk;
  i2c_slave_ctrl dut (.sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .lowPower(lowPower), .wakeReq(wakeReq));
  i2c_bus_master m (.sclLow(sclLow), .sdaLow(sdaLow), .sclLine(sclLine),
    .sdaLine(sdaLine), .hung(hung));
  // =====
  // wake pulse is one cycle long, so latch it
  always @(posedge sys_clk) if (wakeReq === 1'b1) woke <= 1'b1;
  always @(posedge hung) begin
    nFail++;
    conclude();
  end
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    d = regRdata;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task rc(input logic [1:0] a, input logic [7:0] mk, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d & mk, e);
  endtask
  // the clock hold starts a few cycles after the ninth fall
  task hold();
    int n;
    for (n = 0; n < 100 && sclOe !== 1'b1; n++) @(negedge sys_clk);
    if (n == 100) begin
      nFail++;
      conclude();
    end
  endtask
  task send(input logic [7:0] b, input logic expAck);
    m.xfer(b, 1'b1, v, ack);
    chk({7'h0, ack}, {7'h0, expAck});
  endtask
  task recv(input logic [7:0] expB, input logic myAck);
    m.xfer(8'hFF, myAck, v, ack);
    chk(v, expB);
  endtask
  task conclude();
    $display("checks %0d failures %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    rc(`ADDR_MODE, 8'hFF, 8'hE0);
    rc(`ADDR_STAT, 8'hFF, 8'h81);
    rc(`ADDR_OWN, 8'hFF, 8'h00);
    wr(`ADDR_OWN, 8'hA5);
    rc(`ADDR_OWN, 8'hFF, 8'hA5);
    wr(`ADDR_DATA, 8'h3C);
    rc(`ADDR_DATA, 8'hFF, 8'h3C);
    wr(`ADDR_MODE, 8'hFF);
    rc(`ADDR_MODE, 8'hFF, 8'hEF);
    wr(`ADDR_MODE, 8'hC0);
    m.start();
    send(8'hA4, 1'b1);
    m.stop();
    rc(`ADDR_STAT, 8'h20, 8'h00);
    // slow bus: the four-clock filter delays the seen clock fall by up to
    // seven cycles, so data must move well after that or a false START
    // or STOP is seen
    m.halfP = 1000;
    for (int d = 0; d < 4; d++) begin
      wr(`ADDR_MODE, {3'h6, 1'b0, d[1:0], 2'b10});
      m.start();
      send(8'hA4, 1'b0);
      hold();
      rc(`ADDR_STAT, 8'h64, 8'h60);
      rd(`ADDR_DATA, v);
      send(8'h96, 1'b0);
      hold();
      rc(`ADDR_STAT, 8'hA0, 8'hA0);
      rc(`ADDR_DATA, 8'hFF, 8'h96);
      m.stop();
      rc(`ADDR_STAT, 8'h20, 8'h00);
    end
    m.halfP = 200;
    wr(`ADDR_MODE, 8'hC2);
    wr(`ADDR_STAT, 8'h08);
    m.start();
    send(8'hA4, 1'b0);
    hold();
    rd(`ADDR_DATA, v);
    send(8'h5A, 1'b1);
    hold();
    wr(`ADDR_STAT, 8'h00);
    rd(`ADDR_DATA, v);
    send(8'h33, 1'b0);
    hold();
    rd(`ADDR_DATA, v);
    m.stop();
    // transmitter: master takes one byte, then refuses the next
    wr(`ADDR_STAT, 8'h10);
    m.start();
    send(8'hA5, 1'b0);
    hold();
    rc(`ADDR_STAT, 8'h64, 8'h64);
    wr(`ADDR_DATA, 8'hC3);
    recv(8'hC3, 1'b0);
    hold();
    rc(`ADDR_STAT, 8'h01, 8'h00);
    wr(`ADDR_DATA, 8'h5A);
    recv(8'h5A, 1'b1);
    rc(`ADDR_STAT, 8'h01, 8'h01);
    repeat (8) @(negedge sys_clk);
    chk({7'h0, sdaOe}, 8'h00);
    m.stop();
    // re-enable mid-transfer: flags reset, controls kept
    m.start();
    send(8'hA4, 1'b0);
    hold();
    wr(`ADDR_STAT, 8'h18);
    wr(`ADDR_MODE, 8'hC0);
    wr(`ADDR_MODE, 8'hC2);
    rc(`ADDR_STAT, 8'hFD, 8'h99);
    m.stop();
    wr(`ADDR_STAT, 8'h02);
    @(posedge sys_clk) lowPower <= 1'b1;
    m.start();
    send(8'hA4, 1'b0);
    hold();
    chk({7'h0, woke}, 8'h01);
    @(posedge sys_clk) lowPower <= 1'b0;
    wr(`ADDR_STAT, 8'h00);
    rd(`ADDR_DATA, v);
    m.stop();
    m.start();
    send(8'h22, 1'b1);
    m.stop();
    rc(`ADDR_STAT, 8'h60, 8'h00);
    conclude();
  end
endmodule
bind i2c_slave_ctrl i2c_slave_checker chk (.sys_clk(sys_clk),
  .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .sclIn(sclIn), .sclOut(sclOut),
  .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .lowPower(lowPower), .wakeReq(wakeReq));
`default_nettype wire
